// ==== rtl/snl_pkg.sv ====
// How it works
// [RULE1] Bytes travel NRZ over one shared pin.
// [RULE2] Bit period is 256 operating clock cycles.
// [RULE3] Receiver idles until low start bit.
// [RULE4] Stop bit not high means framing error.
// [RULE5] Frame-ok flag set on good stop, cleared otherwise.
// [RULE6] Far side provides pull-up on the pin.
// [RULE7] Idle pin is input with latch zero.
// [RULE8] Transmit shares receiver's bit timing generator. Code: tx_cnt_reg is its own counter; only tick() is shared.
// [RULE9] After sending, pin returns to input, data kept.
// [RULE10] Transceiver never services the watchdog timer.
// [RULE11] Controller must not stall the transceiver mid-character.
// [RULE12] Start, eight data LSB first, stop; mid-bit sampling.
// [RULE13] Zero drives low via direction; one releases pin.
`default_nettype none
package snl_pkg;
  localparam int unsigned SNL_BIT_CYCLES = 256;
  localparam int unsigned SNL_HALF_CYCLES = SNL_BIT_CYCLES / 2;
  localparam int unsigned SNL_DATA_BITS = 8;
  localparam int unsigned SNL_CNT_W = 8;
  localparam int unsigned SNL_IDX_W = 4;
  localparam logic [7:0] SNL_BYTE_RESET = 8'h00;
  localparam logic SNL_LATCH_VALUE = 1'b0;
  typedef enum logic [3:0] {
    SNL_IDLE = 4'h1,
    SNL_START = 4'h2,
    SNL_DATA = 4'h4,
    SNL_STOP = 4'h8
  } snl_state_t;
endpackage
`default_nettype wire

// ==== rtl/snl_stream_if.sv ====
`default_nettype none
interface snl_stream_if;
  logic valid;
  logic ready;
  logic [8:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/snl_skid_buf.sv ====
`default_nettype none
module snl_skid_buf #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next, wr_reg, wr_next;
  logic push, pop;

  always_comb begin
    push = in_valid_i && (cnt_reg != 2'd2);
    pop = (cnt_reg != 2'd0) && out_ready_i;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_i;
      wr_next = ~wr_reg;
    end
    if (pop) begin
      rd_next = ~rd_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'd1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 2'd0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      mem_reg <= mem_next;
    end
  end

  assign in_ready_o = (cnt_reg != 2'd2);
  assign out_valid_o = (cnt_reg != 2'd0);
  assign out_data_o = mem_reg[rd_reg];
endmodule
`default_nettype wire

// ==== rtl/snl_link.sv ====
`default_nettype none
module snl_link #(
  parameter int unsigned BIT_CYCLES = snl_pkg::SNL_BIT_CYCLES
) (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Serial line pin as three signals, plus the direction bit.
  input wire logic serial_line_pin_i,
  output logic serial_line_pin_o,
  output logic serial_line_pin_oe_o,
  output logic line_direction_bit_o,
  // Receive stream: byte plus frame-ok in bit 8.
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_frame_ok_o,
  // Transmit request.
  input wire logic send_byte_op_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_busy_o,
  output logic tx_done_o,
  output logic rx_busy_o
);
  import snl_pkg::*;

  localparam logic [SNL_CNT_W-1:0] CNT_TOP = SNL_CNT_W'(BIT_CYCLES - 1);
  localparam logic [SNL_CNT_W-1:0] CNT_HALF = SNL_CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [SNL_IDX_W-1:0] LAST_BIT = SNL_IDX_W'(SNL_DATA_BITS - 1);

  // Shared bit timing for both directions.
  function automatic logic tick(input logic [SNL_CNT_W-1:0] c);
    tick = (c == CNT_TOP);
  endfunction

  snl_stream_if rxs ();

  // Receive state.
  snl_state_t rx_st_reg, rx_st_next;
  logic [SNL_CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [SNL_IDX_W-1:0] rx_idx_reg, rx_idx_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_ok_reg, rx_ok_next;
  logic rx_hold_reg, rx_hold_next;
  logic rx_push;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg + 1'b1;
    rx_idx_next = rx_idx_reg;
    rx_sh_next = rx_sh_reg;
    rx_ok_next = rx_ok_reg;
    rx_hold_next = rx_hold_reg;
    rx_push = 1'b0;
    case (rx_st_reg)
      SNL_IDLE: begin
        rx_cnt_next = '0;
        // No watchdog strobe leaves this block, so the wait for a start bit has no bound.
        if (!serial_line_pin_i && !tx_busy_o) begin // [RULE3] [RULE10]
          rx_st_next = SNL_START;
        end
      end
      SNL_START: begin
        // Re-check the start at mid-bit so a glitch is dropped.
        if (rx_cnt_reg == CNT_HALF) begin // [RULE12]
          rx_cnt_next = '0;
          rx_idx_next = '0;
          rx_st_next = serial_line_pin_i ? SNL_IDLE : SNL_DATA;
        end
      end
      SNL_DATA: begin
        if (tick(rx_cnt_reg)) begin // [RULE2]
          rx_cnt_next = '0;
          rx_sh_next = {serial_line_pin_i, rx_sh_reg[7:1]}; // [RULE12]
          rx_idx_next = rx_idx_reg + 1'b1;
          if (rx_idx_reg == LAST_BIT) begin
            rx_st_next = SNL_STOP;
          end
        end
      end
      SNL_STOP: begin
        // A full buffer holds the frame here; the stop level is kept from mid-bit, not from later.
        if (tick(rx_cnt_reg)) begin
          rx_cnt_next = rx_cnt_reg;
          if (!rx_hold_reg) begin
            rx_ok_next = serial_line_pin_i; // [RULE4]
          end
          if (rxs.ready) begin
            rx_push = 1'b1; // [RULE1] [RULE4]
            rx_hold_next = 1'b0;
            rx_st_next = SNL_IDLE; // [RULE3]
          end else begin
            rx_hold_next = 1'b1;
          end
        end
      end
      default: begin
        rx_st_next = SNL_IDLE;
      end
    endcase
  end

  assign rxs.valid = rx_push;
  assign rxs.data = {rx_hold_reg ? rx_ok_reg : serial_line_pin_i, rx_sh_reg}; // [RULE5]

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_st_reg <= SNL_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= '0;
      rx_sh_reg <= SNL_BYTE_RESET;
      rx_ok_reg <= 1'b0;
      rx_hold_reg <= 1'b0;
    end else if (ce_i) begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_idx_reg <= rx_idx_next;
      rx_sh_reg <= rx_sh_next;
      rx_ok_reg <= rx_ok_next;
      rx_hold_reg <= rx_hold_next;
    end
  end

  logic buf_valid;
  logic buf_take;
  logic [8:0] buf_data;

  snl_skid_buf #(.WIDTH(9)) u_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_valid_i(rxs.valid),
    .in_ready_o(rxs.ready),
    .in_data_i(rxs.data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_take),
    .out_data_o(buf_data)
  );

  // The output word reloads once taken or while the output is empty, so a registered output never shows a word twice.
  logic rx_valid_next;
  logic [8:0] rx_out_next;
  always_comb begin
    buf_take = !rx_valid_o || rx_ready_i;
    rx_valid_next = rx_valid_o;
    rx_out_next = {rx_frame_ok_o, rx_data_o};
    if (buf_take) begin
      rx_valid_next = buf_valid;
      rx_out_next = buf_data;
    end
  end

  // Transmit state.
  snl_state_t tx_st_reg, tx_st_next;
  logic [SNL_CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic [SNL_IDX_W-1:0] tx_idx_reg, tx_idx_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic dir_reg, dir_next, done_next;

  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg + 1'b1;
    tx_idx_next = tx_idx_reg;
    tx_sh_next = tx_sh_reg;
    dir_next = dir_reg;
    done_next = 1'b0;
    case (tx_st_reg)
      SNL_IDLE: begin
        tx_cnt_next = '0;
        dir_next = 1'b0; // [RULE7]
        if (send_byte_op_i && rx_st_reg == SNL_IDLE) begin
          tx_sh_next = tx_data_i;
          dir_next = 1'b1; // [RULE13]
          tx_st_next = SNL_START;
        end
      end
      SNL_START: begin
        if (tick(tx_cnt_reg)) begin // [RULE8]
          tx_cnt_next = '0;
          tx_idx_next = '0;
          dir_next = ~tx_sh_reg[0]; // [RULE13]
          tx_st_next = SNL_DATA;
        end
      end
      SNL_DATA: begin
        if (tick(tx_cnt_reg)) begin
          tx_cnt_next = '0;
          tx_idx_next = tx_idx_reg + 1'b1;
          if (tx_idx_reg == LAST_BIT) begin
            dir_next = 1'b0; // [RULE12]
            tx_st_next = SNL_STOP;
          end else begin
            dir_next = ~tx_sh_reg[tx_idx_reg[2:0] + 3'd1]; // [RULE13]
          end
        end
      end
      SNL_STOP: begin
        if (tick(tx_cnt_reg)) begin
          dir_next = 1'b0; // [RULE9]
          done_next = 1'b1;
          tx_st_next = SNL_IDLE;
        end
      end
      default: begin
        tx_st_next = SNL_IDLE;
        dir_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_st_reg <= SNL_IDLE;
      tx_cnt_reg <= '0;
      tx_idx_reg <= '0;
      tx_sh_reg <= SNL_BYTE_RESET;
      dir_reg <= 1'b0;
      tx_done_o <= 1'b0;
      tx_busy_o <= 1'b0;
      rx_busy_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= SNL_BYTE_RESET;
      rx_frame_ok_o <= 1'b0;
    end else if (ce_i) begin
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_sh_reg <= tx_sh_next;
      dir_reg <= dir_next;
      tx_done_o <= done_next;
      tx_busy_o <= (tx_st_next != SNL_IDLE);
      rx_busy_o <= (rx_st_next != SNL_IDLE);
      rx_valid_o <= rx_valid_next;
      rx_data_o <= rx_out_next[7:0];
      rx_frame_ok_o <= rx_out_next[8]; // [RULE5]
    end
  end

  // The latch never leaves zero, so the pin is only ever pulled low.
  assign serial_line_pin_o = SNL_LATCH_VALUE; // [RULE7] [RULE9]
  assign serial_line_pin_oe_o = dir_reg; // [RULE13]
  assign line_direction_bit_o = dir_reg;
endmodule
`default_nettype wire

// ==== verif/snl_host_model.sv ====
`default_nettype none
module snl_host_model #(
  parameter int unsigned BIT_CYCLES = 256
) (
  input wire logic clk_i,
  input wire logic oe_i,
  output logic line_o
);
  logic drive_low = 1'b0;
  logic [7:0] sh;
  logic [7:0] got_q[$];
  // The line only falls while a party drives it.
  assign line_o = !(oe_i || drive_low);
  // Whole frame with no pause between bits.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_low <= !f[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
    end
    if (!stop) begin
      drive_low <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Device frames are sampled mid-bit.
  always begin
    @(posedge clk_i);
    if (oe_i) begin
      repeat (BIT_CYCLES / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clk_i);
        sh[i] = line_o;
      end
      repeat (BIT_CYCLES) @(posedge clk_i);
      got_q.push_back(sh);
    end
  end
endmodule
`default_nettype wire

// ==== verif/snl_link_chk.sv ====
`default_nettype none
module snl_link_chk #(
  parameter int unsigned BIT_CYCLES = 256
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic serial_line_pin_o,
  input wire logic serial_line_pin_oe_o,
  input wire logic line_direction_bit_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] rx_data_o,
  input wire logic send_byte_op_i,
  input wire logic tx_busy_o,
  input wire logic tx_done_o,
  input wire logic rx_busy_o
);
  int unsigned busy_cnt_reg;
  always_ff @(posedge clk_i) busy_cnt_reg <= !tx_busy_o ? 0 : (ce_i ? busy_cnt_reg + 1 : busy_cnt_reg);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take;
    ce_i && send_byte_op_i && !tx_busy_o && !rx_busy_o;
  endsequence
  sequence s_start;
    serial_line_pin_oe_o && tx_busy_o;
  endsequence
  a_latch_zero: assert property (serial_line_pin_o == 1'b0) else $error("latch");
  a_start_bit: assert property (s_take |=> s_start) else $error("start");
  a_bit_stand: assert property ($rose(serial_line_pin_oe_o) |-> serial_line_pin_oe_o [*8]) else $error("bit");
  a_frame_time: assert property (tx_done_o |-> busy_cnt_reg == 10 * BIT_CYCLES) else $error("frame");
  a_done_pulse: assert property (tx_done_o |=> !tx_done_o) else $error("done");
  a_idle_release: assert property (!tx_busy_o |-> !serial_line_pin_oe_o) else $error("idle");
  a_dir_match: assert property (line_direction_bit_o == serial_line_pin_oe_o) else $error("dir");
  a_rx_quiet: assert property (rx_busy_o |-> !serial_line_pin_oe_o) else $error("duplex");
  a_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o)) else $error("hold");
endmodule
bind snl_link snl_link_chk #(.BIT_CYCLES(BIT_CYCLES)) snl_link_chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .ce_i(ce_i),
  .serial_line_pin_o(serial_line_pin_o), .serial_line_pin_oe_o(serial_line_pin_oe_o),
  .line_direction_bit_o(line_direction_bit_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
  .rx_data_o(rx_data_o), .send_byte_op_i(send_byte_op_i), .tx_busy_o(tx_busy_o), .tx_done_o(tx_done_o),
  .rx_busy_o(rx_busy_o));
`default_nettype wire

// ==== verif/snl_link_tb_top.sv ====
`default_nettype none
module snl_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // A short bit keeps the run brief; the frame waits and the time limit follow from it.
  localparam int unsigned BC = 16;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic rx_ready_i = 1'b0;
  logic send_byte_op_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic pin_i, pin_o, oe, dir, rx_valid, ok, tx_busy, tx_done, rx_busy;
  logic [7:0] rx_data;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  snl_link #(.BIT_CYCLES(BC)) snl_link_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .serial_line_pin_i(pin_i), .serial_line_pin_o(pin_o), .serial_line_pin_oe_o(oe), .line_direction_bit_o(dir),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data), .rx_frame_ok_o(ok),
    .send_byte_op_i(send_byte_op_i), .tx_data_i(tx_data_i), .tx_busy_o(tx_busy), .tx_done_o(tx_done),
    .rx_busy_o(rx_busy));
  snl_host_model #(.BIT_CYCLES(BC)) snl_host_model_inst (.clk_i(clk_i), .oe_i(oe), .line_o(pin_i));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_tx(input logic [7:0] b);
    @(posedge clk_i);
    send_byte_op_i <= 1'b1;
    tx_data_i <= b;
    @(posedge clk_i);
    send_byte_op_i <= 1'b0;
    for (int i = 0; i < 12 * BC && tx_done !== 1'b1; i++) @(posedge clk_i);
    chk({tx_done, snl_host_model_inst.got_q.pop_front()}, {1'b1, b});
    chk({5'h00, pin_o, oe, dir, tx_busy}, 9'h000);
  endtask
  // A request while the enable is low must leave the block idle.
  task automatic t_freeze();
    ce_i <= 1'b0;
    send_byte_op_i <= 1'b1;
    tx_data_i <= 8'h0f;
    repeat (4) @(posedge clk_i);
    chk({7'h00, tx_busy, oe}, 9'h000);
    send_byte_op_i <= 1'b0;
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({7'h00, tx_busy, oe}, 9'h000);
  endtask
  // One pop, then a pause, as the output lags the buffer head.
  task automatic pop(input logic [8:0] exp);
    for (int i = 0; i < 40 * BC && rx_valid !== 1'b1; i++) @(posedge clk_i);
    chk({8'h00, rx_valid}, 9'h001);
    chk({ok, rx_data}, exp);
    rx_ready_i <= 1'b1;
    @(posedge clk_i);
    rx_ready_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_rx(input logic [7:0] b, input logic stop);
    snl_host_model_inst.send(b, stop);
    pop({stop, b});
    chk({8'h00, rx_busy}, 9'h000);
  endtask
  task automatic t_fill();
    snl_host_model_inst.send(8'h11, 1'b1);
    snl_host_model_inst.send(8'h22, 1'b1);
    snl_host_model_inst.send(8'h33, 1'b1);
    snl_host_model_inst.send(8'h44, 1'b0);
    pop(9'h111);
    pop(9'h122);
    pop(9'h133);
    pop(9'h044);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_freeze();
    t_tx(8'h55);
    t_tx(8'ha3);
    t_rx(8'h3c, 1'b1);
    t_rx(8'h81, 1'b0);
    t_fill();
    summarize();
  end
  initial begin
    #(5 * 300 * BC);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
